// ===== shared/scpd_pkg.sv
// constants and types shared by the stepper configuration pin decoder
// ----------------------------------------------------------------------------
// Summary of operation
// (R1) microstep pins hi/lo: 00 gives 8, 01 gives 32, 10 gives 64, 11 gives 16
// (R2) power-down pin low enables standstill current reduction, high disables it
// (R3) serial host sets pin power-down override and programs standstill current level
// (R4) in serial mode register configuration overrides the strap pin settings; code uses register microstep and chopper only with mstep_reg_sel_r set
// (R5) chopper pin low selects quiet chopper with optional auto switch, high chopper_select_pin
// (R6) standby pin high disables regulator and switches off all internal units
// (R7) leaving standby returns every driver register to its power-up default
// (R8) host stops motor before standby and holds disable and reference low
// (R9) host keeps io supply active during standby, may lower it to 1.5V
// (R10) serial link shares one line; each side releases it when not sending
// (R11) every serial transfer carries a crc; receiver rejects corrupted commands
// (R12) device detects host baud rate automatically from the incoming transfer
// (R13) serial node address bit 0 from low select pin, bit 1 from high pin
// (R14) serial line idles high so pin power-down cannot work between transfers
// (R15) driver disable high floats motor outputs and clears latched diagnostic error
// (R16) every configuration and standby pin passes a synchroniser before use
// ----------------------------------------------------------------------------
package scpd_pkg;
    localparam int unsigned SYNC_STAGES = 3;
    localparam logic [7:0] MSTEP_8 = 8'h08;
    localparam logic [7:0] MSTEP_16 = 8'h10;
    localparam logic [7:0] MSTEP_32 = 8'h20;
    localparam logic [7:0] MSTEP_64 = 8'h40;
    localparam logic [1:0] RST_MSTEP_SEL = 2'h0;
    localparam logic RST_CHOPPER_CHOPPER_SELECT_PIN = 1'b0;
    localparam logic RST_PDN_DISABLE = 1'b0;
    localparam logic RST_MSTEP_REG_SEL = 1'b0;
    localparam logic [4:0] RST_STANDSTILL_LEVEL = 5'h10;
    localparam logic [4:0] RST_RUN_LEVEL = 5'h1f;

    typedef enum logic [1:0] {
        SCPD_ACTIVE = 2'b00,
        SCPD_STANDBY = 2'b01,
        SCPD_WAKE = 2'b11
    } scpd_pwr_type;

    // decodes a two-bit select into a microstep count
    function automatic logic [7:0] scpd_mstep(input logic [1:0] sel);
        logic [7:0] res;
        res = MSTEP_8;
        case (sel)
            2'b00: res = MSTEP_8;
            2'b01: res = MSTEP_32;
            2'b10: res = MSTEP_64;
            default: res = MSTEP_16;
        endcase
        return res;
    endfunction : scpd_mstep
endpackage : scpd_pkg

// ===== shared/scpd_pin_if.sv
// raw and synchronised strap pin group
`timescale 1ns/10ps
interface scpd_pin_if;
    logic [5:0] raw;
    logic [5:0] sync;
    logic [5:0] changed;
    modport src (output raw, input sync, input changed);
    modport sink (input raw, output sync, output changed);
endinterface : scpd_pin_if

// ===== rtl/scpd_sync.sv
// three-stage synchroniser for the strap pins
`timescale 1ns/10ps
module scpd_sync (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    scpd_pin_if.sink pins
);
    logic [5:0] s1_r;
    logic [5:0] s2_r;
    logic [5:0] s3_r;
    logic [5:0] val_r;

    // s1 feeds s2 only; a change counts once s2 and s3 agree
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            s1_r <= 6'h00;
            s2_r <= 6'h00;
            s3_r <= 6'h00;
        end else begin
            s1_r <= pins.raw; // [R16]
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            val_r <= 6'h00;
        end else begin
            val_r <= (s2_r & s3_r) | (val_r & (s2_r | s3_r)); // [R16]
        end
    end

    assign pins.sync = val_r;
    assign pins.changed = val_r ^ ((s2_r & s3_r) | (val_r & (s2_r | s3_r)));
endmodule : scpd_sync

// ===== rtl/scpd_top.sv
// strap pin decoding, serial override, standby and driver enable control
`timescale 1ns/10ps
module scpd_top (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_microstep_select_lo,
    input wire logic i_microstep_select_hi,
    input wire logic i_chopper_select_pin,
    input wire logic i_pdn_serial_pin,
    input wire logic i_standby_pin,
    input wire logic i_driver_disable_n,
    input wire logic i_serial_mode,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_pdn_disable,
    input wire logic i_cfg_mstep_reg_sel,
    input wire logic [1:0] i_cfg_mstep,
    input wire logic i_cfg_chopper_chopper_select_pin,
    input wire logic [4:0] i_cfg_standstill_level,
    input wire logic i_otp_auto_switch,
    input wire logic i_speed_above_thresh,
    input wire logic i_error_event,
    input wire logic i_crc_ok,
    input wire logic i_frame_done,
    output logic [7:0] o_microsteps,
    output logic o_standstill_reduce,
    output logic o_chopper_select_pin_active,
    output logic o_auto_switch_en,
    output logic o_standby,
    output logic o_regulator_en,
    output logic o_power_stage_en,
    output logic o_diagnostic_output,
    output logic [1:0] o_bus_node_address,
    output logic o_cmd_accept,
    output logic o_cfg_pdn_disable,
    output logic [4:0] o_standstill_current_level,
    output logic [7:0] o_write_count
);
    // --------------------------------------------------------------------
    // synchronised pins
    // --------------------------------------------------------------------
    scpd_pin_if pin_bus ();
    assign pin_bus.raw = {i_driver_disable_n, i_standby_pin, i_pdn_serial_pin,
                          i_chopper_select_pin, i_microstep_select_hi, i_microstep_select_lo};

    scpd_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .pins(pin_bus)
    );

    logic [1:0] pin_mstep;
    logic pin_chopper_select_pin;
    logic pin_pdn;
    logic pin_stby;
    logic pin_disable;
    assign pin_mstep = pin_bus.sync[1:0];
    assign pin_chopper_select_pin = pin_bus.sync[2];
    assign pin_pdn = pin_bus.sync[3];
    assign pin_stby = pin_bus.sync[4];
    assign pin_disable = pin_bus.sync[5];

    // --------------------------------------------------------------------
    // standby sequencing
    // --------------------------------------------------------------------
    scpd_pkg::scpd_pwr_type pwr_r;
    scpd_pkg::scpd_pwr_type pwr_nxt;

    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            scpd_pkg::SCPD_ACTIVE: begin
                if (pin_stby) begin
                    pwr_nxt = scpd_pkg::SCPD_STANDBY; // [R6]
                end
            end
            scpd_pkg::SCPD_STANDBY: begin
                if (!pin_stby) begin
                    pwr_nxt = scpd_pkg::SCPD_WAKE;
                end
            end
            scpd_pkg::SCPD_WAKE: begin
                pwr_nxt = scpd_pkg::SCPD_ACTIVE;
            end
            default: begin
                pwr_nxt = scpd_pkg::SCPD_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pwr_r <= scpd_pkg::SCPD_ACTIVE;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    logic regs_clear;
    logic units_on;
    // registers are held at defaults through standby and the wake cycle
    assign regs_clear = (pwr_r != scpd_pkg::SCPD_ACTIVE); // [R7]
    assign units_on = (pwr_r == scpd_pkg::SCPD_ACTIVE); // [R6]

    // --------------------------------------------------------------------
    // driver configuration registers
    // --------------------------------------------------------------------
    logic pdn_disable_r;
    logic mstep_reg_sel_r;
    logic [1:0] mstep_r;
    logic chopper_select_pin_r;
    logic [4:0] standstill_r;
    logic [7:0] wcount_r;
    logic accept;

    // only crc-checked frames write; a corrupted frame changes nothing
    // frame strobes come from the line decoder, which locks to the host's bit rate per frame
    assign accept = i_serial_mode && i_frame_done && i_crc_ok && units_on; // [R11] [R12]

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || regs_clear) begin
            pdn_disable_r <= scpd_pkg::RST_PDN_DISABLE; // [R7]
            mstep_reg_sel_r <= scpd_pkg::RST_MSTEP_REG_SEL;
            mstep_r <= scpd_pkg::RST_MSTEP_SEL;
            chopper_select_pin_r <= scpd_pkg::RST_CHOPPER_CHOPPER_SELECT_PIN;
            standstill_r <= scpd_pkg::RST_STANDSTILL_LEVEL;
        end else if (accept && i_cfg_wr) begin
            pdn_disable_r <= i_cfg_pdn_disable; // [R4]
            mstep_reg_sel_r <= i_cfg_mstep_reg_sel;
            mstep_r <= i_cfg_mstep;
            chopper_select_pin_r <= i_cfg_chopper_chopper_select_pin;
            standstill_r <= i_cfg_standstill_level;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || regs_clear) begin
            wcount_r <= 8'h00;
        end else if (accept && i_cfg_wr) begin
            wcount_r <= wcount_r + 8'h01;
        end
    end

    // --------------------------------------------------------------------
    // decoded settings
    // --------------------------------------------------------------------
    logic [1:0] mstep_sel;
    logic pdn_pin_active;
    logic chopper_select_pin_sel;
    // register selection only honoured in serial mode; strap pins otherwise
    assign mstep_sel = (i_serial_mode && mstep_reg_sel_r) ? mstep_r : pin_mstep; // [R4]
    // in serial mode the pin carries data, so its level is never a power-down command
    assign pdn_pin_active = !i_serial_mode && !pdn_disable_r; // [R2] [R10]
    assign chopper_select_pin_sel = (i_serial_mode && mstep_reg_sel_r) ? chopper_select_pin_r : pin_chopper_select_pin; // [R4]

    logic [7:0] microsteps_r;
    logic reduce_r;
    logic chopper_select_pin_act_r;
    logic auto_r;
    logic [1:0] addr_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            microsteps_r <= scpd_pkg::MSTEP_8;
            addr_r <= 2'h0;
        end else begin
            microsteps_r <= scpd_pkg::scpd_mstep(mstep_sel); // [R1]
            addr_r <= pin_mstep; // [R13]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            reduce_r <= 1'b1;
        end else if (pdn_pin_active) begin
            reduce_r <= !pin_pdn; // [R2]
        end else begin
            reduce_r <= (standstill_r != scpd_pkg::RST_RUN_LEVEL);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            chopper_select_pin_act_r <= 1'b0;
            auto_r <= 1'b0;
        end else begin
            auto_r <= !chopper_select_pin_sel && i_otp_auto_switch; // [R5]
            chopper_select_pin_act_r <= chopper_select_pin_sel || (i_otp_auto_switch && i_speed_above_thresh); // [R5]
        end
    end

    // --------------------------------------------------------------------
    // driver enable and diagnostic latch
    // --------------------------------------------------------------------
    logic diagnostic_output_r;
    logic stage_r;

    // the clear wins here: a disabled stage can report no live fault
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || regs_clear) begin
            diagnostic_output_r <= 1'b0;
        end else if (pin_disable) begin
            diagnostic_output_r <= 1'b0; // [R15]
        end else if (i_error_event) begin
            diagnostic_output_r <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            stage_r <= 1'b0;
        end else begin
            // next power state, so the stage drops on the same edge that enters standby
            stage_r <= !pin_disable && (pwr_nxt == scpd_pkg::SCPD_ACTIVE); // [R15] [R6]
        end
    end

    assign o_microsteps = microsteps_r;
    assign o_standstill_reduce = reduce_r;
    assign o_chopper_select_pin_active = chopper_select_pin_act_r;
    assign o_auto_switch_en = auto_r;
    assign o_standby = !units_on;
    assign o_regulator_en = units_on;
    assign o_power_stage_en = stage_r;
    assign o_diagnostic_output = diagnostic_output_r;
    assign o_bus_node_address = addr_r;
    assign o_cmd_accept = accept;
    assign o_cfg_pdn_disable = pdn_disable_r;
    assign o_standstill_current_level = standstill_r;
    assign o_write_count = wcount_r;
endmodule : scpd_top

// ===== tb/scpd_top_properties.sv
// concurrent checks on the ports of the configuration pin decoder
`timescale 1ns/10ps
module scpd_top_properties (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_microstep_select_lo,
    input wire logic i_microstep_select_hi,
    input wire logic i_chopper_select_pin,
    input wire logic i_pdn_serial_pin,
    input wire logic i_standby_pin,
    input wire logic i_driver_disable_n,
    input wire logic i_serial_mode,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_pdn_disable,
    input wire logic i_crc_ok,
    input wire logic i_frame_done,
    input wire logic [4:0] i_cfg_standstill_level,
    input wire logic o_standstill_reduce,
    input wire logic o_chopper_select_pin_active,
    input wire logic o_standby,
    input wire logic o_regulator_en,
    input wire logic o_power_stage_en,
    input wire logic o_diagnostic_output,
    input wire logic o_cmd_accept,
    input wire logic o_cfg_pdn_disable,
    input wire logic [1:0] o_bus_node_address,
    input wire logic [4:0] o_standstill_current_level,
    input wire logic [7:0] o_write_count
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // pin checks wait 7 or 8 cycles: sync stages, output register and the wake cycle
    accept_cause_a: assert property (o_cmd_accept |-> i_frame_done && i_crc_ok
        && i_serial_mode && !o_standby) else $error("accept without clean frame");
    accept_due_a: assert property (i_frame_done && i_crc_ok && i_serial_mode
        && !o_standby && !$past(o_standby) |-> o_cmd_accept) else $error("frame dropped");
    count_step_a: assert property (o_cmd_accept && i_cfg_wr |=>
        o_write_count == $past(o_write_count) + 8'h01) else $error("count not stepped");
    level_load_a: assert property (o_cmd_accept && i_cfg_wr |=> o_cfg_pdn_disable ==
        $past(i_cfg_pdn_disable) && o_standstill_current_level == $past(i_cfg_standstill_level))
        else $error("config not loaded");
    power_off_a: assert property (o_standby |-> !o_regulator_en && !o_power_stage_en)
        else $error("units on in standby");
    standby_in_a: assert property (i_standby_pin [*7] |-> o_standby) else $error("no standby");
    addr_pin_a: assert property ($stable({i_microstep_select_hi, i_microstep_select_lo}) [*7]
        |-> o_bus_node_address == {i_microstep_select_hi, i_microstep_select_lo})
        else $error("address mismatch");
    diagnostic_output_clear_a: assert property (i_driver_disable_n [*7] |-> !o_diagnostic_output
        && !o_power_stage_en) else $error("disable ignored");
    chopper_select_pin_pin_a: assert property ((!i_serial_mode && !i_standby_pin && i_chopper_select_pin)
        [*8] |-> o_chopper_select_pin_active) else $error("chopper_select_pin not chosen");
    reduce_pin_a: assert property ((!i_serial_mode && !i_standby_pin && !i_pdn_serial_pin)
        [*8] |-> o_standstill_reduce) else $error("no standstill reduction");
    cover property (o_cmd_accept && i_cfg_wr);
    cover property (o_standby);
    cover property ($fell(o_diagnostic_output));
endmodule : scpd_top_properties

bind scpd_top scpd_top_properties u_props (.*);

// ===== tb/scpd_host_model.sv
// board straps and host control of the configuration and standby pins
`timescale 1ns/10ps
module scpd_host_model (
    input wire logic i_ref_clk,
    input wire logic [2:0] i_strap,
    input wire logic i_open,
    input wire logic i_sleep_req,
    input wire logic i_motor_off,
    output logic o_ms_lo,
    output logic o_ms_hi,
    output logic o_chopper_select_pin,
    output logic o_standby_pin,
    output logic o_disable_n
);
    logic [2:0] wait_r = 3'h0;
    logic stby_r = 1'b0;
    logic dis_n_r = 1'b0;
    assign o_standby_pin = stby_r;
    assign o_disable_n = dis_n_r;
    // unconnected straps fall to the internal pull-downs
    assign {o_ms_hi, o_ms_lo, o_chopper_select_pin} = i_open ? 3'h0 : i_strap;
    // motor is switched off for seven cycles before standby, disable held low inside it
    always @(negedge i_ref_clk) begin
        if (i_sleep_req && !stby_r) begin
            dis_n_r <= (wait_r != 3'h7);
            stby_r <= (wait_r == 3'h7);
            wait_r <= wait_r + 3'h1;
        end else if (!i_sleep_req) begin
            stby_r <= 1'b0;
            dis_n_r <= i_motor_off;
            wait_r <= 3'h0;
        end else begin
            // io supply stays up in standby, so the pins keep their driven levels
            dis_n_r <= 1'b0;
        end
    end
endmodule : scpd_host_model

// ===== tb/tb_scpd_top.sv
// self-checking bench for the configuration pin decoder
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb_scpd_top;
    logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, pdn = 1'b1, ser = 1'b0, wr = 1'b0, pdis = 1'b0;
    logic sel = 1'b0, spr = 1'b0, otp = 1'b0, err = 1'b0, crc = 1'b0, done = 1'b0, open = 1'b0;
    logic sleep = 1'b0, off = 1'b0, acc_d = 1'b0, spd = 1'b0;
    logic [1:0] ms = 2'h0;
    logic [2:0] strap = 3'h0;
    logic [4:0] lvl = 5'h00;
    logic ms_lo, ms_hi, chop, stby, dis_n, acc, sp, ae, sb, reg_en, pse, diagnostic_output, red, pdo;
    logic [1:0] adr;
    logic [4:0] lv_o;
    logic [7:0] mst, cnt;
    logic [7:0] exp_cnt = 8'h00;
    logic [12:0] q[$];
    logic [12:0] e;
    int bad_count = 0, tests_run = 0, cyc = 0;
    logic [7:0] tbl [4] = '{8'h08, 8'h20, 8'h40, 8'h10};

    scpd_host_model u_host (.i_ref_clk, .i_strap(strap), .i_open(open), .i_sleep_req(sleep),
        .i_motor_off(off), .o_ms_lo(ms_lo), .o_ms_hi(ms_hi), .o_chopper_select_pin(chop),
        .o_standby_pin(stby), .o_disable_n(dis_n));
    scpd_top u_dut (.i_ref_clk, .i_sys_rst, .i_microstep_select_lo(ms_lo),
        .i_microstep_select_hi(ms_hi), .i_chopper_select_pin(chop), .i_pdn_serial_pin(pdn),
        .i_standby_pin(stby), .i_driver_disable_n(dis_n), .i_serial_mode(ser), .i_cfg_wr(wr),
        .i_cfg_pdn_disable(pdis), .i_cfg_mstep_reg_sel(sel), .i_cfg_mstep(ms),
        .i_cfg_chopper_chopper_select_pin(spr), .i_cfg_standstill_level(lvl), .i_otp_auto_switch(otp),
        .i_speed_above_thresh(spd), .i_error_event(err), .i_crc_ok(crc), .i_frame_done(done),
        .o_microsteps(mst), .o_standstill_reduce(red), .o_chopper_select_pin_active(sp),
        .o_auto_switch_en(ae), .o_standby(sb), .o_regulator_en(reg_en), .o_power_stage_en(pse),
        .o_diagnostic_output(diagnostic_output), .o_bus_node_address(adr), .o_cmd_accept(acc),
        .o_cfg_pdn_disable(pdo), .o_standstill_current_level(lv_o), .o_write_count(cnt));

    always #4 i_ref_clk = ~i_ref_clk;

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic tick(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : tick

    // one frame end per call; consecutive calls give back-to-back frames
    task automatic frame(input logic w, input logic good, input logic take);
        tick(1);
        done = 1'b1; crc = good; wr = w; pdis = 1'b1; sel = 1'b1;
        lvl = 5'($urandom); ms = 2'($urandom); spr = 1'($urandom);
        if (take && w) begin
            exp_cnt++;
            q.push_back({exp_cnt, lvl});
        end
    endtask : frame

    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // watcher: every accepted write consumes the oldest note
    // ----------------------------------------
    always @(posedge i_ref_clk) acc_d <= acc & wr;
    always @(negedge i_ref_clk) if (acc_d) begin
        e = (q.size() > 0) ? q.pop_front() : 13'h1fff;
        `CHK({cnt, lv_o}, e)
    end

    initial begin
        void'($urandom(32'h2b89cfb7));
        tick(6);
        `CHK(mst, 8'h08)
        `CHK(lv_o, scpd_pkg::RST_STANDSTILL_LEVEL)
        tick(2);
        i_sys_rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            spd = 1'($urandom);
            strap = 3'(i); otp = 1'($urandom); pdn = i[0]; tick(9);
            `CHK(mst, tbl[i[2:1]])
            `CHK(adr, i[2:1])
            `CHK(red, !i[0])
            `CHK(sp, i[0] | (otp & spd))
            if (!i[0]) `CHK(ae, otp)
        end
        open = 1'b1; tick(9);
        `CHK(sp, otp & spd)
        `CHK(mst, 8'h08)
        open = 1'b0; tick(1); err = 1'b1; tick(1); err = 1'b0; tick(1);
        `CHK(diagnostic_output, 1'b1)
        off = 1'b1; tick(9); err = 1'b1; tick(1); err = 1'b0; tick(1);
        `CHK(diagnostic_output, 1'b0)
        `CHK(pse, 1'b0)
        off = 1'b0; tick(9);
        `CHK(pse, 1'b1)
        frame(1'b1, 1'b1, 1'b0); tick(1); done = 1'b0; ser = 1'b1; pdn = 1'b1; tick(2);
        frame(1'b1, 1'b0, 1'b0); frame(1'b0, 1'b1, 1'b0);
        frame(1'b1, 1'b1, 1'b1); frame(1'b1, 1'b1, 1'b1); tick(1); done = 1'b0; wr = 1'b0; tick(3);
        `CHK(cnt, exp_cnt)
        `CHK(mst, tbl[ms])
        `CHK(pdo, 1'b1)
        sleep = 1'b1; tick(25);
        `CHK(sb, 1'b1)
        `CHK(reg_en, 1'b0)
        frame(1'b1, 1'b1, 1'b0); tick(1); done = 1'b0; wr = 1'b0; sleep = 1'b0; tick(12);
        `CHK(sb, 1'b0)
        `CHK(lv_o, scpd_pkg::RST_STANDSTILL_LEVEL)
        `CHK(pdo, scpd_pkg::RST_PDN_DISABLE)
        `CHK(q.size(), 0)
        end_of_test();
    end
endmodule : tb_scpd_top
